// ==== hw/lsc_line_state_controller.sv ====
// Line state controller: mode decode, auto activation, ringing and fault flags
`timescale 1ns/10ps

module lsc_line_state_controller #(
  parameter int unsigned STBY_CYC = lsc_pkg::STBY_CHECK_CYC
) (
  input  wire logic sys_clk_i,           // Free-running oscillator clock
  input  wire logic rstn_i,              // Power-on reset, active low
  input  wire logic device_init_n_i,     // Init pin, active low
  input  wire logic input_select_n_i,    // Write strobe for control bits
  input  wire logic output_select_n_i,   // Read strobe for flags
  input  wire logic state_sel_msb_i,     // State-select bit, msb
  input  wire logic state_sel_mid_i,     // State-select bit, middle
  input  wire logic state_sel_lsb_i,     // State-select bit, lsb
  input  wire logic aux_relay_a_ctrl_i,  // Auxiliary relay A control bit
  input  wire logic aux_relay_b_ctrl_i,  // Auxiliary relay B control bit
  input  wire logic off_hook_i,          // Line off-hook detector
  input  wire logic ring_trip_i,         // Ring-trip detector
  input  wire logic overvoltage_sense_i, // Overvoltage current detector
  input  wire logic long_fault_i,        // Longitudinal current detector
  input  wire logic thermal_alarm_i,     // Junction over-temperature
  input  wire logic ring_phase_clock_i,  // Ring-phase clock pin
  output logic      ring_relay_drive_o,  // Ring relay driver on
  output logic      aux_relay_a_drive_o, // Auxiliary relay A driver on
  output logic      aux_relay_b_drive_o, // Auxiliary relay B driver on
  output logic      hook_flag_n_o,       // Hook flag, low active
  output logic      fault_flag_n_o,      // Fault flag, low active
  output logic      flag_oe_o,           // Flags driven onto the bus
  output lsc_pkg::lsc_line_e line_state_o, // Feeding condition of the line
  output logic      polarity_rev_o,      // Reverse feeding polarity
  output logic      current_limit_o      // Line current limit engaged
);

  lsc_pkg::lsc_state_s r;    // Registered state
  lsc_pkg::lsc_state_s nxt;  // Next state

  logic [lsc_pkg::NIN-1:0] pins;    // Raw pin vector
  logic [lsc_pkg::NIN-1:0] f;       // Filtered pin levels
  logic [2:0]              sel_w;   // Word on the bus
  logic                    init_ok; // Init pin released
  logic                    wr_stb;  // End of a write strobe
  logic                    mode_chg;// Write that alters the mode
  logic                    offhook; // Filtered off-hook
  logic                    trip;    // Filtered ring-trip
  logic                    overv;   // Filtered overvoltage
  logic                    lfault;  // Filtered longitudinal fault
  logic                    therm;   // Filtered thermal alarm
  logic                    rclk;    // Filtered ring-phase clock
  logic                    rclk_rise; // Start of a ring-phase period
  logic                    auto_run;  // Automatic machine in charge

  // Gather pins into one vector for the three-stage filter
  assign pins = {ring_phase_clock_i, thermal_alarm_i, long_fault_i,
                 overvoltage_sense_i, ring_trip_i, off_hook_i,
                 device_init_n_i, output_select_n_i, input_select_n_i,
                 aux_relay_b_ctrl_i, aux_relay_a_ctrl_i,
                 state_sel_msb_i, state_sel_mid_i, state_sel_lsb_i};

  // Decoded views of the filtered inputs
  assign f         = r.filt;
  assign sel_w     = {f[lsc_pkg::IN_SEL_MSB], f[lsc_pkg::IN_SEL_MID],
                      f[lsc_pkg::IN_SEL_LSB]};
  assign init_ok   = f[lsc_pkg::IN_INIT_N];
  assign offhook   = f[lsc_pkg::IN_OFFHOOK];
  assign trip      = f[lsc_pkg::IN_TRIP];
  assign overv     = f[lsc_pkg::IN_OVERV];
  assign lfault    = f[lsc_pkg::IN_LONG];
  assign therm     = f[lsc_pkg::IN_THERM];
  assign rclk      = f[lsc_pkg::IN_RCLK];
  assign rclk_rise = rclk & ~r.rclk_prev;
  // Data is taken as the input strobe returns high, when it has settled
  assign wr_stb    = init_ok & f[lsc_pkg::IN_INPUT_SELECT_N_N] & ~r.input_select_n_prev;
  assign mode_chg  = wr_stb & (sel_w != r.mode);
  assign auto_run  = init_ok & ~therm & r.mode[2];

  // Next-state logic
  always_comb begin
    nxt = r;
    // Three-stage filter: a level counts once stages two and three agree
    nxt.sync1     = pins;
    nxt.sync2     = r.sync1;
    nxt.sync3     = r.sync2;
    nxt.filt      = (r.sync2 & r.sync3) | (r.filt & (r.sync2 | r.sync3));
    nxt.input_select_n_prev = f[lsc_pkg::IN_INPUT_SELECT_N_N];
    nxt.rclk_prev = rclk;

    // Automatic activation, stepping on the internal clock
    if (auto_run) begin
      case (r.auto_st)
        lsc_pkg::AUTO_HIZ: begin
          // Any off-hook starts the validity check
          if (offhook) begin
            nxt.auto_st  = lsc_pkg::AUTO_STBY;
            nxt.stby_cnt = 16'h0000;
          end
        end
        lsc_pkg::AUTO_STBY: begin
          // Spurious detection returns without activating
          if (!offhook) begin
            nxt.auto_st = lsc_pkg::AUTO_HIZ;
          end else if (r.stby_cnt == 16'(STBY_CYC - 1)) begin
            nxt.auto_st    = lsc_pkg::AUTO_ACT;
            nxt.onhook_per = 8'h00;
          end else begin
            nxt.stby_cnt = r.stby_cnt + 16'h0001;
          end
        end
        lsc_pkg::AUTO_ACT: begin
          // Short on-hook gaps (dial pulses) only restart the count
          if (offhook) begin
            nxt.onhook_per = 8'h00;
          end else if (rclk_rise) begin
            // Falls back only once on-hook outlasts the full count of periods
            if (r.onhook_per == 8'(lsc_pkg::ONHOOK_PERIODS)) begin
              // Reverse-polarity word holds the call up indefinitely
              if (r.mode != lsc_pkg::MODE_ACT_REV) begin
                nxt.auto_st = lsc_pkg::AUTO_HIZ;
              end
            end else begin
              nxt.onhook_per = r.onhook_per + 8'h01;
            end
          end
        end
        default: begin
          nxt.auto_st = lsc_pkg::AUTO_HIZ;
        end
      endcase
    end

    // Control bits from the parallel bus
    if (wr_stb) begin
      nxt.mode  = sel_w;
      nxt.aux_a = f[lsc_pkg::IN_AUX_A];
      nxt.aux_b = f[lsc_pkg::IN_AUX_B];
    end
    // A new mode word releases the trip latch; a new 1XX word also restarts the machine
    if (mode_chg) begin
      nxt.trip_latched = 1'b0;
      if (sel_w[2]) begin
        nxt.auto_st    = lsc_pkg::AUTO_HIZ;
        nxt.stby_cnt   = 16'h0000;
        nxt.onhook_per = 8'h00;
      end
    end
    // Overload leaves the machine waiting in high impedance
    if (therm) begin
      nxt.auto_st = lsc_pkg::AUTO_HIZ;
    end
    // Ring-trip latch; a trip wins over a clear in the same cycle
    if (init_ok && r.mode == lsc_pkg::MODE_RING && trip) begin
      nxt.trip_latched = 1'b1;
    end
    // Init pin held low: everything back to idle
    if (!init_ok) begin
      nxt.mode         = lsc_pkg::MODE_RST;
      nxt.aux_a        = 1'b0;
      nxt.aux_b        = 1'b0;
      nxt.auto_st      = lsc_pkg::AUTO_HIZ;
      nxt.trip_latched = 1'b0;
      nxt.stby_cnt     = 16'h0000;
      nxt.onhook_per   = 8'h00;
    end

    // Ring relay: switched on in a ring-clock low, held, dropped at once
    if (init_ok && !therm && r.mode == lsc_pkg::MODE_RING &&
        !r.trip_latched && !trip) begin
      nxt.ring_relay = r.ring_relay | ~rclk;
    end else begin
      nxt.ring_relay = 1'b0;
    end

    // Auxiliary relays follow their bits, also under overload
    nxt.aux_a_drv = init_ok & r.aux_a;
    nxt.aux_b_drv = init_ok & r.aux_b;

    // Feeding condition and polarity from the mode word
    nxt.pol_rev = 1'b0;
    if (!init_ok || therm) begin
      nxt.line = lsc_pkg::LINE_PDOWN;
    end else begin
      case (r.mode)
        lsc_pkg::MODE_PDOWN: begin
          nxt.line = lsc_pkg::LINE_PDOWN;
        end
        lsc_pkg::MODE_RING: begin
          nxt.line = lsc_pkg::LINE_RING;
        end
        lsc_pkg::MODE_OHT_REV: begin
          nxt.line    = lsc_pkg::LINE_OHT;
          nxt.pol_rev = 1'b1;
        end
        lsc_pkg::MODE_OHT_DIR: begin
          nxt.line = lsc_pkg::LINE_OHT;
        end
        default: begin
          // Words 1XX: internal state decides; high impedance is direct
          case (r.auto_st)
            lsc_pkg::AUTO_STBY: nxt.line = lsc_pkg::LINE_STBY;
            lsc_pkg::AUTO_ACT:  nxt.line = lsc_pkg::LINE_ACT;
            default:            nxt.line = lsc_pkg::LINE_HIZ;
          endcase
          nxt.pol_rev = (r.mode == lsc_pkg::MODE_ACT_REV) &&
                        (r.auto_st != lsc_pkg::AUTO_HIZ);
        end
      endcase
    end

    // Flags: faults override, otherwise per mode
    nxt.fault_n   = 1'b1;
    nxt.hook_n    = 1'b1;
    nxt.cur_limit = init_ok & lfault;
    if (!init_ok) begin
      nxt.hook_n  = 1'b1;
      nxt.fault_n = 1'b1;
    end else if (therm || overv || lfault) begin
      nxt.hook_n  = 1'b0;
      nxt.fault_n = 1'b0;
    end else if (r.mode == lsc_pkg::MODE_RING) begin
      nxt.hook_n = ~(r.trip_latched | trip);
    end else if (r.mode != lsc_pkg::MODE_PDOWN) begin
      nxt.hook_n = ~offhook;
    end
    nxt.flag_oe = ~f[lsc_pkg::IN_OUTPUT_SELECT_N_N];
  end

  // State register
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r              <= '0;
      r.sync1        <= lsc_pkg::IN_RST_VAL;
      r.sync2        <= lsc_pkg::IN_RST_VAL;
      r.sync3        <= lsc_pkg::IN_RST_VAL;
      r.filt         <= lsc_pkg::IN_RST_VAL;
      r.input_select_n_prev    <= 1'b1;
      r.mode         <= lsc_pkg::MODE_RST;
      r.auto_st      <= lsc_pkg::AUTO_HIZ;
      r.line         <= lsc_pkg::LINE_PDOWN;
      r.hook_n       <= 1'b1;
      r.fault_n      <= 1'b1;
    end else begin
      r <= nxt;
    end
  end

  // Outputs straight from the state register
  assign ring_relay_drive_o  = r.ring_relay;
  assign aux_relay_a_drive_o = r.aux_a_drv;
  assign aux_relay_b_drive_o = r.aux_b_drv;
  assign hook_flag_n_o       = r.hook_n;
  assign fault_flag_n_o      = r.fault_n;
  assign flag_oe_o           = r.flag_oe;
  assign line_state_o        = r.line;
  assign polarity_rev_o      = r.pol_rev;
  assign current_limit_o     = r.cur_limit;

  // Relay only ever rises from a low ring-phase level
  property p_relay_low;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      $rose(ring_relay_drive_o) |-> !$past(rclk);
  endproperty
  a_relay_low: assert property (p_relay_low) else $error("relay on in clock high");

  // Trip drops the relay and pulls the hook flag next cycle
  property p_trip_off;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (init_ok && r.mode == lsc_pkg::MODE_RING && trip && !therm)
        |=> (!ring_relay_drive_o && !hook_flag_n_o);
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("ring trip not handled");

  // Latch survives until a changed mode word or init
  property p_trip_hold;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (r.trip_latched && init_ok && !mode_chg) |=> r.trip_latched;
  endproperty
  a_trip_hold: assert property (p_trip_hold) else $error("trip latch lost");

  // A changed 1XX word restarts in high impedance
  property p_hiz_entry;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (mode_chg && sel_w[2] && !therm) |=> (r.auto_st == lsc_pkg::AUTO_HIZ);
  endproperty
  a_hiz_entry: assert property (p_hiz_entry) else $error("no hiz after word");

  // High impedance never reports reverse polarity
  property p_hiz_dir;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (line_state_o == lsc_pkg::LINE_HIZ) |-> !polarity_rev_o;
  endproperty
  a_hiz_dir: assert property (p_hiz_dir) else $error("reverse in hiz");

  // Off-hook in high impedance moves to stand-by within one cycle
  property p_to_stby;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (auto_run && r.auto_st == lsc_pkg::AUTO_HIZ && offhook && !mode_chg)
        |=> (r.auto_st == lsc_pkg::AUTO_STBY);
  endproperty
  a_to_stby: assert property (p_to_stby) else $error("no stand-by step");

  // Dropped off-hook in stand-by returns to high impedance
  property p_reject;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (auto_run && r.auto_st == lsc_pkg::AUTO_STBY && !offhook)
        |=> (r.auto_st == lsc_pkg::AUTO_HIZ);
  endproperty
  a_reject: assert property (p_reject) else $error("false activation");

  // Overvoltage pulls both flags, mode word untouched
  property p_overv;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (init_ok && overv && !wr_stb)
        |=> (!hook_flag_n_o && !fault_flag_n_o && r.mode == $past(r.mode));
  endproperty
  a_overv: assert property (p_overv) else $error("overvoltage flags wrong");

  // Thermal overload: power-down line, relay off, flags low
  property p_therm;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (init_ok && therm) |=> (line_state_o == lsc_pkg::LINE_PDOWN &&
                              !ring_relay_drive_o && !hook_flag_n_o && !fault_flag_n_o);
  endproperty
  a_therm: assert property (p_therm) else $error("thermal response wrong");

  // Init low releases flags and auxiliary relays
  property p_init;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      !init_ok |=> (hook_flag_n_o && fault_flag_n_o && !aux_relay_a_drive_o &&
                    !aux_relay_b_drive_o && line_state_o == lsc_pkg::LINE_PDOWN);
  endproperty
  a_init: assert property (p_init) else $error("init not idling");

endmodule

// ==== include/lsc_pkg.sv ====
// Constants, codes and the state record of the line state controller
package lsc_pkg;

  // Clock period and ring-phase low time
  localparam int unsigned CLK_PERIOD_PS    = 4000;
  localparam int unsigned RING_LOW_MIN_US  = 1;
  localparam int unsigned RING_LOW_MIN_CYC =
    (RING_LOW_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // On-hook persistence in ring-phase periods before falling back
  localparam int unsigned ONHOOK_PERIODS   = 128;
  // Default length of the stand-by off-hook check, oscillator cycles
  localparam int unsigned STBY_CHECK_CYC   = 1024;

  // State-select words, msb first
  localparam logic [2:0] MODE_PDOWN   = 3'h0;
  localparam logic [2:0] MODE_RING    = 3'h1;
  localparam logic [2:0] MODE_OHT_REV = 3'h2;
  localparam logic [2:0] MODE_OHT_DIR = 3'h3;
  localparam logic [2:0] MODE_ACT_REV = 3'h6;
  localparam logic [2:0] MODE_RST     = MODE_PDOWN;

  // Positions of the pin inputs in the synchroniser vector
  localparam int unsigned IN_SEL_LSB  = 0;
  localparam int unsigned IN_SEL_MID  = 1;
  localparam int unsigned IN_SEL_MSB  = 2;
  localparam int unsigned IN_AUX_A    = 3;
  localparam int unsigned IN_AUX_B    = 4;
  localparam int unsigned IN_INPUT_SELECT_N_N   = 5;
  localparam int unsigned IN_OUTPUT_SELECT_N_N  = 6;
  localparam int unsigned IN_INIT_N   = 7;
  localparam int unsigned IN_OFFHOOK  = 8;
  localparam int unsigned IN_TRIP     = 9;
  localparam int unsigned IN_OVERV    = 10;
  localparam int unsigned IN_LONG     = 11;
  localparam int unsigned IN_THERM    = 12;
  localparam int unsigned IN_RCLK     = 13;
  localparam int unsigned NIN         = 14;
  // Idle pin levels assumed while reset is applied (strobes high)
  localparam logic [NIN-1:0] IN_RST_VAL = 14'h0060;

  // Internal automatic states within an active mode word
  typedef enum logic [1:0] {AUTO_HIZ, AUTO_STBY, AUTO_ACT} lsc_auto_e;

  // Line condition reported to the analog side
  typedef enum logic [2:0] {
    LINE_PDOWN, LINE_RING, LINE_OHT, LINE_HIZ, LINE_STBY, LINE_ACT
  } lsc_line_e;

  // Whole register state of the controller
  typedef struct packed {
    logic [NIN-1:0] sync1;
    logic [NIN-1:0] sync2;
    logic [NIN-1:0] sync3;
    logic [NIN-1:0] filt;
    logic           input_select_n_prev;
    logic           rclk_prev;
    logic [2:0]     mode;
    logic           aux_a;
    logic           aux_b;
    lsc_auto_e      auto_st;
    logic           trip_latched;
    logic [7:0]     onhook_per;
    logic [15:0]    stby_cnt;
    lsc_line_e      line;
    logic           ring_relay;
    logic           aux_a_drv;
    logic           aux_b_drv;
    logic           hook_n;
    logic           fault_n;
    logic           flag_oe;
    logic           pol_rev;
    logic           cur_limit;
  } lsc_state_s;

endpackage

// ==== tb/line_state_controller_bench.sv ====
// Self-checking bench of the line state controller
`timescale 1ns/10ps
module line_state_controller_bench;
  localparam int unsigned STBY = 40;   // Shortened stand-by check
  logic sys_clk, rstn, init_n, input_select_n_n, output_select_n_n, aux_a, aux_b, rclk;
  logic [2:0] sel;                     // Mode word from the controller
  logic off_hook, trip, overv, long_flt, therm;  // Line detectors
  logic relay, drv_a, drv_b, hook_n, fault_n, oe, pol, ilim;
  lsc_pkg::lsc_line_e line;            // Feeding condition seen
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;                         // Cycle count for the time limit

  lsc_line_state_controller #(.STBY_CYC(STBY)) i_lsc_line_state_controller (
    .sys_clk_i(sys_clk), .rstn_i(rstn), .device_init_n_i(init_n),
    .input_select_n_i(input_select_n_n), .output_select_n_i(output_select_n_n),
    .state_sel_msb_i(sel[2]), .state_sel_mid_i(sel[1]), .state_sel_lsb_i(sel[0]),
    .aux_relay_a_ctrl_i(aux_a), .aux_relay_b_ctrl_i(aux_b), .off_hook_i(off_hook),
    .ring_trip_i(trip), .overvoltage_sense_i(overv), .long_fault_i(long_flt),
    .thermal_alarm_i(therm), .ring_phase_clock_i(rclk), .ring_relay_drive_o(relay),
    .aux_relay_a_drive_o(drv_a), .aux_relay_b_drive_o(drv_b), .hook_flag_n_o(hook_n),
    .fault_flag_n_o(fault_n), .flag_oe_o(oe), .line_state_o(line),
    .polarity_rev_o(pol), .current_limit_o(ilim));

  lsc_ctrl_model i_lsc_ctrl_model (
    .sys_clk_i(sys_clk), .flag_oe_i(oe), .hook_flag_n_i(hook_n),
    .fault_flag_n_i(fault_n), .device_init_n_o(init_n), .input_select_n_o(input_select_n_n),
    .output_select_n_o(output_select_n_n), .state_sel_o(sel), .aux_a_o(aux_a),
    .aux_b_o(aux_b), .ring_phase_clock_o(rclk));

  // Clock generator, 4 ns period
  initial sys_clk = 1'b0;
  always #2 sys_clk = ~sys_clk;

  // Cut a hang short
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      summarize();
    end
  end

  // Wait a number of clock edges
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Compare and count
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Compare the line state
  task automatic cl(input lsc_pkg::lsc_line_e e);
    chk("line", 8'(e), 8'(line));
  endtask

  // Verdict and end of run
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Every mode word once, with the expected condition and polarity
  task automatic t_decode();
    lsc_pkg::lsc_line_e e;
    for (int w = 0; w < 8; w++) begin
      e = (w == 0) ? lsc_pkg::LINE_PDOWN : (w == 1) ? lsc_pkg::LINE_RING :
          (w < 4) ? lsc_pkg::LINE_OHT : lsc_pkg::LINE_HIZ;
      i_lsc_ctrl_model.wr(3'(w), 1'b0, 1'b0);
      step(4);
      cl(e);
      chk("pol", 8'(w == 2), 8'(pol));
    end
    $display("decode done");
  endtask

  // Ringing, synchronised start, ring-trip and its latch
  task automatic t_ring();
    i_lsc_ctrl_model.wr(3'h0, 1'b0, 1'b0);
    @(posedge rclk);
    i_lsc_ctrl_model.wr(3'h1, 1'b0, 1'b0);
    step(8);
    chk("relay_hi", 8'h00, 8'(relay));
    @(negedge rclk);
    step(8);
    chk("relay_lo", 8'h01, 8'(relay));
    @(posedge sys_clk) trip <= 1'b1;
    step(6);
    chk("relay_trip", 8'h00, 8'(relay));
    chk("hook_trip", 8'h00, 8'(hook_n));
    trip <= 1'b0;
    i_lsc_ctrl_model.wr(3'h1, 1'b0, 1'b0);
    step(10);
    chk("hook_held", 8'h00, 8'(hook_n));
    i_lsc_ctrl_model.wr(3'h0, 1'b0, 1'b0);
    step(4);
    chk("hook_clr", 8'h01, 8'(hook_n));
    i_lsc_ctrl_model.wr(3'h1, 1'b0, 1'b0);
    step(4);
    chk("hook_rel", 8'h01, 8'(hook_n));
    $display("ring done");
  endtask

  // Automatic activation, rejection, dialling pulses and fallback
  task automatic t_auto();
    i_lsc_ctrl_model.wr(3'h4, 1'b0, 1'b0);
    step(4);
    cl(lsc_pkg::LINE_HIZ);
    off_hook <= 1'b1;
    step(8);
    cl(lsc_pkg::LINE_STBY);
    off_hook <= 1'b0;
    step(8);
    cl(lsc_pkg::LINE_HIZ);
    off_hook <= 1'b1;
    step(STBY + 20);
    cl(lsc_pkg::LINE_ACT);
    chk("hook_act", 8'h00, 8'(hook_n));
    off_hook <= 1'b0;
    step(10);
    chk("hook_on", 8'h01, 8'(hook_n));
    cl(lsc_pkg::LINE_ACT);
    off_hook <= 1'b1;
    step(10);
    off_hook <= 1'b0;
    repeat (128) @(posedge rclk);
    step(8);
    cl(lsc_pkg::LINE_ACT);
    repeat (2) @(posedge rclk);
    step(8);
    cl(lsc_pkg::LINE_HIZ);
    i_lsc_ctrl_model.wr(3'h6, 1'b0, 1'b0);
    off_hook <= 1'b1;
    step(STBY + 20);
    cl(lsc_pkg::LINE_ACT);
    chk("pol_act_rev", 8'h01, 8'(pol));
    off_hook <= 1'b0;
    $display("auto done");
  endtask

  // On-hook transmission stays ready while on-hook
  task automatic t_oht();
    i_lsc_ctrl_model.wr(3'h3, 1'b0, 1'b0);
    repeat (5) @(posedge rclk);
    step(1);
    cl(lsc_pkg::LINE_OHT);
    $display("oht done");
  endtask

  // Overvoltage, longitudinal fault, thermal overload
  task automatic t_fault();
    logic h, f;
    i_lsc_ctrl_model.wr(3'h4, 1'b1, 1'b1);
    overv <= 1'b1;
    step(6);
    i_lsc_ctrl_model.rd(h, f);
    chk("ov_flags", 8'h00, {6'h00, h, f});
    chk("disc", 8'h01, 8'(i_lsc_ctrl_model.line_disc_r));
    cl(lsc_pkg::LINE_HIZ);
    overv <= 1'b0;
    long_flt <= 1'b1;
    step(6);
    chk("lf", 8'h01, {5'h00, hook_n, fault_n, ilim});
    long_flt <= 1'b0;
    step(6);
    chk("lf_end", 8'h00, 8'(ilim));
    i_lsc_ctrl_model.wr(3'h1, 1'b1, 1'b0);
    @(negedge rclk);
    step(8);
    therm <= 1'b1;
    step(6);
    chk("th", 8'h02, {3'h0, relay, hook_n, fault_n, drv_a, drv_b});
    cl(lsc_pkg::LINE_PDOWN);
    i_lsc_ctrl_model.wr(3'h1, 1'b0, 1'b1);
    step(4);
    chk("th_aux", 8'h01, {6'h00, drv_a, drv_b});
    therm <= 1'b0;
    $display("fault done");
  endtask

  // Init pin forces power-down, relays off, flags released
  task automatic t_init();
    i_lsc_ctrl_model.wr(3'h4, 1'b1, 1'b1);
    off_hook <= 1'b1;
    i_lsc_ctrl_model.set_init(1'b0);
    step(8);
    chk("init", 8'h03, {4'h0, drv_a, drv_b, hook_n, fault_n});
    cl(lsc_pkg::LINE_PDOWN);
    i_lsc_ctrl_model.set_init(1'b1);
    $display("init done");
  endtask

  // Main sequence
  initial begin
    rstn = 1'b0;
    off_hook = 1'b0;
    trip = 1'b0;
    overv = 1'b0;
    long_flt = 1'b0;
    therm = 1'b0;
    step(5);
    chk("rst", 8'h03, {4'h0, relay, oe, hook_n, fault_n});
    rstn <= 1'b1;
    step(6);
    t_decode();
    t_ring();
    t_auto();
    t_oht();
    t_fault();
    t_init();
    summarize();
  end
endmodule

// ==== tb/lsc_ctrl_model.sv ====
// Card controller model: mode word writes, flag reads, ring-phase clock
`timescale 1ns/10ps
module lsc_ctrl_model (
  input  wire logic        sys_clk_i,          // Bench clock
  input  wire logic        flag_oe_i,          // Flags qualified on the bus
  input  wire logic        hook_flag_n_i,      // Hook flag from the block
  input  wire logic        fault_flag_n_i,     // Fault flag from the block
  output logic             device_init_n_o,    // Init pin, active low
  output logic             input_select_n_o,   // Write strobe
  output logic             output_select_n_o,  // Read strobe
  output logic [2:0]       state_sel_o,        // Mode word, msb first
  output logic             aux_a_o,            // Relay A control bit
  output logic             aux_b_o,            // Relay B control bit
  output logic             ring_phase_clock_o  // Ring-phase clock
);
  // Low phase kept above the minimum, so the block never sees a short low
  localparam int unsigned RLOW = lsc_pkg::RING_LOW_MIN_CYC + 10;
  localparam int unsigned PER  = RLOW + 20;
  logic [15:0] rcnt_r = 16'h0000;  // Position within the ring period
  logic        line_disc_r = 1'b0; // External line disconnect relay

  initial begin
    device_init_n_o   = 1'b1;
    input_select_n_o  = 1'b1;
    output_select_n_o = 1'b1;
    state_sel_o       = 3'h0;
    aux_a_o           = 1'b0;
    aux_b_o           = 1'b0;
  end

  // Free-running ring clock, never stopped, as the state machine needs it
  always @(posedge sys_clk_i) begin
    rcnt_r <= (rcnt_r == 16'(PER - 1)) ? 16'h0000 : rcnt_r + 16'h0001;
  end
  assign ring_phase_clock_o = (rcnt_r >= 16'(RLOW));

  // Write one word; data held over the whole strobe, both phases filtered
  task automatic wr(input logic [2:0] w, input logic a, input logic b);
    @(posedge sys_clk_i);
    state_sel_o      <= w;
    aux_a_o          <= a;
    aux_b_o          <= b;
    input_select_n_o <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    input_select_n_o <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
  endtask

  // Read flags: hold the select until the qualifier is sampled high
  task automatic rd(output logic h, output logic f);
    int i;
    @(posedge sys_clk_i) output_select_n_o <= 1'b0;
    i = 0;
    do begin
      @(posedge sys_clk_i);
      i++;
    end while (flag_oe_i !== 1'b1 && i < 12);
    h = (i < 12) ? hook_flag_n_i : 1'bx;
    f = (i < 12) ? fault_flag_n_i : 1'bx;
    // Both flags low means a power-cross: cut the line off
    if (h === 1'b0 && f === 1'b0) line_disc_r <= 1'b1;
    output_select_n_o <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
  endtask

  // Drive the init pin
  task automatic set_init(input logic v);
    @(posedge sys_clk_i) device_init_n_o <= v;
  endtask
endmodule
